//--- sac_device.sv
`default_nettype none
// Function
// - conversion timed by own clock count
// - host holds trigger low 40 ns
// - busy high from trigger fall to done
// - acquisition starts busy fall or select fall
// - select low at trigger fall
// - drive bus only select and read low
// - trigger fall switches track to hold
// - host input activity in first 400 ns
// - auto-read trigger high within 400 ns
// - bus quiet 125 ns before trigger fall
// - release bus 125 ns before acquisition end
// - host leaves 200 ns acquisition interval
// - auto-read with select, read tied low
// - straight binary sixteen bit result
// - byte select moves low byte up
// - host toggles read three times first
// - trigger during conversion resets, clears result
module sac_device #(
  parameter int CONV_CYCLES = sac_pkg::CONV_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to host
  sac_if.dev lnk,
  // converter core side
  input wire logic [15:0] sample_code,
  output logic tracking,
  output logic conv_done
);
  typedef enum logic [2:0] {
    SAC_ACQ = 3'b001,
    SAC_CONV = 3'b010,
    SAC_WAIT = 3'b100
  } sac_state_e;

  sac_state_e state, next_state;
  logic [2:0] trig_s, sel_s, rd_s, byte_s;
  logic [2:0] next_trig_s, next_sel_s, next_rd_s, next_byte_s;
  logic trig_q, sel_q, rd_q, byte_q;
  logic next_trig_q, next_sel_q, next_rd_q, next_byte_q;
  logic [10:0] cnt, next_cnt;
  logic [15:0] result, next_result;
  logic [15:0] held, next_held;
  logic [15:0] bus_out, next_bus_out;
  logic bus_oe, next_bus_oe;
  logic trk, next_trk;
  logic done, next_done;
  logic trig_fall, sel_fall;

  // three-stage pin sync; level accepted when stages 2 and 3 agree
  always_comb begin
    next_trig_s = {trig_s[1:0], lnk.sample_trigger_n};
    next_sel_s = {sel_s[1:0], lnk.select_n};
    next_rd_s = {rd_s[1:0], lnk.read_n};
    next_byte_s = {byte_s[1:0], lnk.byte_sel};
    next_trig_q = (trig_s[2] == trig_s[1]) ? trig_s[2] : trig_q;
    next_sel_q = (sel_s[2] == sel_s[1]) ? sel_s[2] : sel_q;
    next_rd_q = (rd_s[2] == rd_s[1]) ? rd_s[2] : rd_q;
    next_byte_q = (byte_s[2] == byte_s[1]) ? byte_s[2] : byte_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_s <= 3'h7;
      sel_s <= 3'h7;
      rd_s <= 3'h7;
      byte_s <= 3'h0;
      trig_q <= 1'b1;
      sel_q <= 1'b1;
      rd_q <= 1'b1;
      byte_q <= 1'b0;
    end else begin
      trig_s <= next_trig_s;
      sel_s <= next_sel_s;
      rd_s <= next_rd_s;
      byte_s <= next_byte_s;
      trig_q <= next_trig_q;
      sel_q <= next_sel_q;
      rd_q <= next_rd_q;
      byte_q <= next_byte_q;
    end
  end

  assign trig_fall = next_trig_q == 1'b0 && trig_q == 1'b1 && next_sel_q == 1'b0;
  assign sel_fall = next_sel_q == 1'b0 && sel_q == 1'b1;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_result = result;
    next_held = held;
    next_trk = trk;
    next_done = 1'b0;
    case (state)
      SAC_ACQ: begin
        if (trig_fall) begin
          next_held = sample_code;
          next_trk = 1'b0;
          next_cnt = 11'h000;
          next_state = SAC_CONV;
        end
      end
      SAC_CONV: begin
        if (trig_fall) begin
          next_result = sac_pkg::RESULT_RST;
          next_cnt = 11'h000;
          next_trk = 1'b1;
          next_state = SAC_ACQ;
        end else if (cnt == 11'(CONV_CYCLES - 1)) begin
          next_result = held;
          next_done = 1'b1;
          if (sel_q == 1'b0) begin
            next_trk = 1'b1;
            next_state = SAC_ACQ;
          end else begin
            next_state = SAC_WAIT;
          end
        end else begin
          next_cnt = cnt + 11'h001;
        end
      end
      SAC_WAIT: begin
        if (sel_fall) begin
          next_trk = 1'b1;
          next_state = SAC_ACQ;
        end
      end
      default: begin
        next_state = SAC_ACQ;
        next_trk = 1'b1;
      end
    endcase
  end

  // output bus
  always_comb begin
    // drive only when selected and read
    next_bus_oe = sel_q == 1'b0 && rd_q == 1'b0;
    // byte mode low byte on top
    if (byte_q) begin
      next_bus_out = {next_result[7:0], sac_pkg::BYTE_FILL};
    end else begin
      // new result appears with no strobe
      next_bus_out = next_result;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SAC_ACQ;
      cnt <= 11'h000;
      result <= sac_pkg::RESULT_RST;
      held <= sac_pkg::RESULT_RST;
      trk <= 1'b1;
      done <= 1'b0;
      bus_out <= sac_pkg::RESULT_RST;
      bus_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      result <= next_result;
      held <= next_held;
      trk <= next_trk;
      done <= next_done;
      bus_out <= next_bus_out;
      bus_oe <= next_bus_oe;
    end
  end

  assign lnk.busy = state == SAC_CONV;
  assign lnk.result_bus_out = bus_out;
  assign lnk.result_bus_oe = bus_oe;
  assign tracking = trk;
  assign conv_done = done;
endmodule
`default_nettype wire

//--- sac_host.sv
`default_nettype none
module sac_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to device
  sac_if.host lnk,
  // user side
  input wire logic start,
  input wire logic byte_mode,
  output logic ready,
  output logic [15:0] data,
  output logic data_valid
);
  typedef enum logic [6:0] {
    SH_INIT = 7'b0000001,
    SH_IDLE = 7'b0000010,
    SH_TRIG = 7'b0000100,
    SH_WBUSY = 7'b0001000,
    SH_RD = 7'b0010000,
    SH_RD2 = 7'b0100000,
    SH_GAP = 7'b1000000
  } sh_state_e;

  sh_state_e state, next_state;
  logic [2:0] busy_s, next_busy_s;
  logic busy_q, next_busy_q;
  logic [3:0] cnt, next_cnt;
  logic [1:0] nreads, next_nreads;
  logic trig_n, next_trig_n, sel_n, next_sel_n, rd_n, next_rd_n, bsel, next_bsel;
  logic [15:0] word, next_word;
  logic dv, next_dv;
  logic seen_busy, next_seen_busy;

  always_comb begin
    next_busy_s = {busy_s[1:0], lnk.busy};
    next_busy_q = (busy_s[2] == busy_s[1]) ? busy_s[2] : busy_q;
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt + 4'h1;
    next_nreads = nreads;
    next_trig_n = trig_n;
    next_sel_n = sel_n;
    next_rd_n = rd_n;
    next_bsel = bsel;
    next_word = word;
    next_dv = 1'b0;
    next_seen_busy = seen_busy;
    case (state)
      SH_INIT: begin
        if (cnt[0]) begin
          next_rd_n = ~rd_n;
          if (rd_n == 1'b0) begin
            next_nreads = nreads + 2'h1;
            if (nreads == 2'(sac_pkg::INIT_READS - 1)) begin
              next_state = SH_GAP;
              next_cnt = 4'h0;
            end
          end
        end
      end
      SH_IDLE: begin
        if (start) begin
          next_sel_n = 1'b0;
          next_trig_n = 1'b0;
          next_cnt = 4'h0;
          next_seen_busy = 1'b0;
          next_state = SH_TRIG;
        end
      end
      SH_TRIG: begin
        // low time rounded up, within limit
        if (cnt == 4'(sac_pkg::TRIG_LOW_CYC + 1)) begin
          next_trig_n = 1'b1;
          next_state = SH_WBUSY;
        end
      end
      SH_WBUSY: begin
        if (busy_q) begin
          next_seen_busy = 1'b1;
        end
        if (seen_busy && !busy_q) begin
          next_rd_n = 1'b0;
          next_bsel = 1'b0;
          next_cnt = 4'h0;
          next_state = SH_RD;
        end
      end
      SH_RD: begin
        // wait pin sync plus register delay
        if (cnt == 4'h6) begin
          next_word = lnk.result_bus_out;
          next_cnt = 4'h0;
          if (byte_mode) begin
            next_bsel = 1'b1;
            next_state = SH_RD2;
          end else begin
            next_rd_n = 1'b1;
            next_dv = 1'b1;
            next_state = SH_GAP;
          end
        end
      end
      SH_RD2: begin
        if (cnt == 4'h6) begin
          next_word = {word[15:8], lnk.result_bus_out[15:8]};
          next_rd_n = 1'b1;
          next_bsel = 1'b0;
          next_dv = 1'b1;
          next_cnt = 4'h0;
          next_state = SH_GAP;
        end
      end
      SH_GAP: begin
        next_sel_n = 1'b1;
        if (cnt == 4'(sac_pkg::ACQ_CYC + sac_pkg::QUIET_CYC)) begin
          next_state = SH_IDLE;
        end
      end
      default: next_state = SH_INIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SH_INIT;
      busy_s <= 3'h0;
      busy_q <= 1'b0;
      cnt <= 4'h0;
      nreads <= 2'h0;
      trig_n <= 1'b1;
      sel_n <= 1'b0;
      rd_n <= 1'b1;
      bsel <= 1'b0;
      word <= 16'h0000;
      dv <= 1'b0;
      seen_busy <= 1'b0;
    end else begin
      state <= next_state;
      busy_s <= next_busy_s;
      busy_q <= next_busy_q;
      cnt <= next_cnt;
      nreads <= next_nreads;
      trig_n <= next_trig_n;
      sel_n <= next_sel_n;
      rd_n <= next_rd_n;
      bsel <= next_bsel;
      word <= next_word;
      dv <= next_dv;
      seen_busy <= next_seen_busy;
    end
  end

  assign lnk.sample_trigger_n = trig_n;
  assign lnk.select_n = sel_n;
  assign lnk.read_n = rd_n;
  assign lnk.byte_sel = bsel;
  assign ready = state == SH_IDLE;
  assign data = word;
  assign data_valid = dv;
endmodule
`default_nettype wire

//--- sac_if.sv
`default_nettype none
interface sac_if;
  logic sample_trigger_n;
  logic select_n;
  logic read_n;
  logic byte_sel;
  logic busy;
  logic [15:0] result_bus_out;
  logic result_bus_oe;
  modport dev (
    input sample_trigger_n, select_n, read_n, byte_sel,
    output busy, result_bus_out, result_bus_oe
  );
  modport host (
    output sample_trigger_n, select_n, read_n, byte_sel,
    input busy, result_bus_out, result_bus_oe
  );
endinterface
`default_nettype wire

//--- sac_pkg.sv
`default_nettype none
package sac_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RES_W = 16;
  localparam int BYTE_W = 8;
  // conversion time in ns (1.13 us)
  localparam int CONV_TIME_NS = 1130;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int TRIG_LOW_NS = 40;
  localparam int TRIG_LOW_CYC = (TRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_MAX_NS = 400;
  localparam int TRIG_MAX_CYC = TRIG_MAX_NS / CLK_PERIOD_NS;
  localparam int QUIET_NS = 125;
  localparam int QUIET_CYC = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_NS = 200;
  localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_READS = 3;
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_FILL = 8'hff;
endpackage
`default_nettype wire

//--- sac_props.sv
`default_nettype none
module sac_props #(
  parameter int CONV_CYCLES = sac_pkg::CONV_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link signals
  input wire logic sample_trigger_n,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic byte_sel,
  input wire logic busy,
  input wire logic [15:0] result_bus_out,
  input wire logic result_bus_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] busy_cnt;
  logic [7:0] next_busy_cnt;
  always_comb begin
    next_busy_cnt = busy ? busy_cnt + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk) begin
    busy_cnt <= rst ? 8'h00 : next_busy_cnt;
  end
  sequence s_trig_fall;
    $fell(sample_trigger_n) && !select_n;
  endsequence
  sequence s_trig_pulse;
    !sample_trigger_n [*2];
  endsequence
  property p_conv_len;
    $fell(busy) |-> int'(busy_cnt) == CONV_CYCLES;
  endproperty
  property p_busy_rise;
    s_trig_fall ##0 !busy |-> ##[1:6] busy;
  endproperty
  property p_trig_width;
    s_trig_fall |-> s_trig_pulse;
  endproperty
  property p_trig_max;
    $fell(sample_trigger_n) |-> ##[1:8] sample_trigger_n;
  endproperty
  property p_sel_low;
    $fell(sample_trigger_n) |-> !select_n;
  endproperty
  property p_acq_gap;
    $fell(busy) |-> sample_trigger_n [*4];
  endproperty
  property p_quiet;
    $fell(sample_trigger_n) |-> read_n && $past(read_n, 1) && $past(read_n, 2) && $past(read_n, 3);
  endproperty
  property p_bus_off;
    read_n [*7] |-> !result_bus_oe;
  endproperty
  // host pins stay still once the first 400 ns of a conversion are over
  property p_quiet_conv;
    busy && busy_cnt > 8'h08 |-> $stable(select_n) && $stable(read_n) && $stable(byte_sel)
      && $stable(sample_trigger_n);
  endproperty
  property p_fill;
    byte_sel [*7] ##0 result_bus_oe |-> result_bus_out[7:0] == sac_pkg::BYTE_FILL;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("busy length wrong");
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
  a_trig_width: assert property (p_trig_width) else $error("trigger pulse short");
  a_trig_max: assert property (p_trig_max) else $error("trigger low too long");
  a_sel_low: assert property (p_sel_low) else $error("trigger without select");
  a_acq_gap: assert property (p_acq_gap) else $error("acquisition gap short");
  a_quiet: assert property (p_quiet) else $error("bus not quiet at trigger");
  a_bus_off: assert property (p_bus_off) else $error("bus driven without read");
  a_fill: assert property (p_fill) else $error("lower lane not filled");
  a_quiet_conv: assert property (p_quiet_conv) else $error("host pin moved late in conversion");
endmodule
`default_nettype wire

//--- sac_tb_top.sv
`default_nettype none
module sac_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst;
  logic start;
  logic byte_mode;
  logic [15:0] sample_code;
  logic [15:0] code_b;
  logic ready;
  logic [15:0] data;
  logic data_valid;
  logic tracking_b;
  logic conv_done_b;
  int done_cnt = 0;
  logic [15:0] codes [5];
  int miscompares;
  int n_tests;
  sac_if a_lnk();
  sac_if b_lnk();
  sac_device sac_device_inst (.clk(clk), .rst(rst), .lnk(a_lnk), .sample_code(sample_code), .tracking(),
    .conv_done());
  // second device faces the bench so the host rules can be broken
  sac_device sac_device_inst_b (.clk(clk), .rst(rst), .lnk(b_lnk), .sample_code(code_b),
    .tracking(tracking_b), .conv_done(conv_done_b));
  always @(posedge clk) begin
    if (conv_done_b === 1'b1) begin
      done_cnt++;
    end
  end
  sac_host sac_host_inst (.clk(clk), .rst(rst), .lnk(a_lnk), .start(start), .byte_mode(byte_mode),
    .ready(ready), .data(data), .data_valid(data_valid));
  sac_props sac_props_inst (.clk(clk), .rst(rst), .sample_trigger_n(a_lnk.sample_trigger_n),
    .select_n(a_lnk.select_n), .read_n(a_lnk.read_n), .byte_sel(a_lnk.byte_sel), .busy(a_lnk.busy),
    .result_bus_out(a_lnk.result_bus_out), .result_bus_oe(a_lnk.result_bus_oe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic host_conv(input logic [15:0] code, input logic mode);
    int i;
    sample_code = code;
    byte_mode = mode;
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 400 && data_valid !== 1'b1; i++) @(negedge clk);
    check(data, code);
  endtask
  task automatic b_wait(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && b_lnk.busy !== lvl; i++) @(negedge clk);
  endtask
  // trigger held two cycles, well under the 400 ns ceiling
  task automatic b_pulse();
    b_lnk.sample_trigger_n = 1'b0;
    repeat (2) @(negedge clk);
    b_lnk.sample_trigger_n = 1'b1;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    start = 1'b0;
    byte_mode = 1'b0;
    sample_code = 16'h0000;
    code_b = 16'h1234;
    codes = '{16'h0000, 16'h8000, 16'h7fff, 16'hffff, 16'ha5c3};
    b_lnk.sample_trigger_n = 1'b1;
    b_lnk.select_n = 1'b0;
    b_lnk.read_n = 1'b0;
    b_lnk.byte_sel = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      host_conv(codes[i], i[0]);
      host_conv(codes[i], ~i[0]);
    end
    // auto-read path with select and read low
    repeat (10) @(negedge clk);
    b_pulse();
    b_wait(1'b1, 8);
    check({15'h0000, b_lnk.busy}, 16'h0001);
    check({15'h0000, tracking_b}, 16'h0000);
    b_wait(1'b0, 40);
    repeat (6) @(negedge clk);
    check(b_lnk.result_bus_out, 16'h1234);
    check({15'h0000, b_lnk.result_bus_oe}, 16'h0001);
    b_lnk.byte_sel = 1'b1;
    repeat (7) @(negedge clk);
    check(b_lnk.result_bus_out, 16'h34ff);
    b_lnk.byte_sel = 1'b0;
    b_lnk.read_n = 1'b1;
    repeat (7) @(negedge clk);
    check({15'h0000, b_lnk.result_bus_oe}, 16'h0000);
    b_lnk.read_n = 1'b0;
    repeat (10) @(negedge clk);
    // second fall inside the conversion must abort it
    b_pulse();
    b_wait(1'b1, 8);
    repeat (2) @(negedge clk);
    b_pulse();
    b_wait(1'b0, 8);
    check({15'h0000, b_lnk.busy}, 16'h0000);
    repeat (6) @(negedge clk);
    check(b_lnk.result_bus_out, 16'h0000);
    b_lnk.select_n = 1'b1;
    repeat (10) @(negedge clk);
    b_pulse();
    repeat (8) @(negedge clk);
    check({15'h0000, b_lnk.busy}, 16'h0000);
    b_lnk.select_n = 1'b0;
    repeat (10) @(negedge clk);
    b_pulse();
    b_wait(1'b1, 8);
    check({15'h0000, b_lnk.busy}, 16'h0001);
    b_wait(1'b0, 40);
    // select high at the end parks the device until select falls
    repeat (10) @(negedge clk);
    b_pulse();
    b_wait(1'b1, 8);
    b_lnk.select_n = 1'b1;
    b_wait(1'b0, 40);
    repeat (2) @(negedge clk);
    check({15'h0000, tracking_b}, 16'h0000);
    b_lnk.select_n = 1'b0;
    repeat (8) @(negedge clk);
    check({15'h0000, tracking_b}, 16'h0001);
    check(16'(done_cnt), 16'h0003);
    report_and_stop();
  end
endmodule
`default_nettype wire
